// *** hdl/aws_regs.vh ***
// Constants for the ARINC word store-and-send block.
// Assumes a 200 MHz system clock; ARINC timing is counted in 1 MHz ticks.
`ifndef AWS_REGS_VH
`define AWS_REGS_VH

// Host command opcodes
`define AWS_OP_LUT_WR1   8'h14
`define AWS_OP_LUT_WR2   8'h28
`define AWS_OP_MATCH_WR1 8'h18
`define AWS_OP_MATCH_WR2 8'h2C
`define AWS_OP_LUT_RD1   8'h98
`define AWS_OP_LUT_RD2   8'hB8
`define AWS_OP_MATCH_RD1 8'h9C
`define AWS_OP_MATCH_RD2 8'hBC
`define AWS_OP_FIFO_RD1  8'hA0
`define AWS_OP_FIFO_RD2  8'hC0
`define AWS_OP_MB_HI1    4'hA
`define AWS_OP_MB_HI2    4'hC
`define AWS_OP_TX_LOAD   8'h0C
`define AWS_OP_TX_SEND   8'h40
`define AWS_OP_SOFT_RST  8'h44

// Word layout
`define AWS_SD_LO_POS    8
`define AWS_SD_HI_POS    9
`define AWS_MATCH_RST    24'h000000

// FIFO sizes and flag levels
`define AWS_FIFO_DEPTH   32
`define AWS_FIFO_AW      5
`define AWS_FIFO_HALF    6'h10
`define AWS_FIFO_FULL    6'h20

// Timing: clock period, ARINC reference period, tick count
`define AWS_CLK_NS       5
`define AWS_ACLK_NS      1000
`define AWS_TICK_CYC     (`AWS_ACLK_NS / `AWS_CLK_NS)
`define AWS_HS_DATA      9'd5
`define AWS_HS_NULL      9'd5
`define AWS_HS_GAP       9'd40
`define AWS_LS_DATA      9'd40
`define AWS_LS_NULL      9'd40
`define AWS_LS_GAP       9'd320

`endif

// *** hdl/aws_top.v ***
// ARINC word store-and-send: receive filtering, mailboxes, FIFOs, serializer.
// Assumes decoded host commands and received words on the same clock.
`include "aws_regs.vh"
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module aws_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 32,
  parameter AW    = 5,
  parameter OVW   = 0
) (
  input  wire             clk,
  input  wire             rst,
  input  wire             flush,
  input  wire             in_valid,
  input  wire [WIDTH-1:0] in_data,
  output wire             in_ready,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data,
  output wire [AW:0]      count
);
  localparam [AW:0] FULLC = DEPTH[AW:0];
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_q;
  reg [AW-1:0]    rd_q;
  reg [AW:0]      cnt_q;
  wire full = (cnt_q == FULLC);
  wire pop  = out_ready && (cnt_q != {(AW+1){1'b0}});
  wire push = in_valid && (!full || pop);
  // Overwrite mode rewrites the newest slot instead of refusing
  wire ovw  = (OVW != 0) && in_valid && full && !pop;

  assign in_ready  = !full;
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data  = mem[rd_q];
  assign count     = cnt_q;

  always @(posedge clk) begin
    if (push)
      mem[wr_q] <= in_data;
    else if (ovw)
      mem[wr_q - 1'b1] <= in_data;
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_q  <= {AW{1'b0}};
      rd_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else if (flush) begin
      wr_q  <= {AW{1'b0}};
      rd_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push)
        wr_q <= wr_q + 1'b1;
      if (pop)
        rd_q <= rd_q + 1'b1;
      if (push && !pop)
        cnt_q <= cnt_q + 1'b1;
      else if (pop && !push)
        cnt_q <= cnt_q - 1'b1;
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Mailbox captures matching label only while capture enable is set.
// - Match values written and read in one command, mailbox 3 first.
// - Mailboxes keep the 24 non-label bits, read by per-mailbox commands.
// - Each of six mailboxes has an available pin and status bit.
// - Receiver interrupt pin fires on selected mailbox capture.
// - FIFO loads only when label and S/D filters both pass.
// - Per-receiver 256-bit label table, one accepts, zero discards.
// - Label table readable by receiver-specific command.
// - Receive FIFO stores the whole 32-bit word with label.
// - Empty FIFO flags empty only; one word popped per read command.
// - Receive FIFO holds 32; extra words overwrite the last slot.
// - Receive half flag high at 16 or more words.
// - Flag pin shows selected empty, half, full or not-empty.
// - Load command queues a word; loads refused while transmit FIFO full and no word leaves that cycle.
// - Transmit half flag low below 16 words.
// - Parity enabled puts odd parity in bit 32, else data unchanged.
// - Auto mode starts sending when the loading command ends.
// - Manual mode sends all queued words on the send command.
// - First data bit appears within 2.5 reference clocks.
// - Bit, null and gap lengths of 5/5/40 or 40/40/320 clocks.
// - Transmit empty set after every loaded word has gone out.
// - Soft reset command empties all three FIFOs.
// - S/D mismatch drops the word before any label filtering.
// - Rate bit selects high-speed or low-speed counts.
module aws_top (
  input  wire        clk,
  input  wire        rst,
  input  wire        cmd_valid,
  input  wire [7:0]  cmd_op,
  input  wire [4:0]  cmd_idx,
  input  wire [31:0] cmd_wdata,
  input  wire        cmd_end,
  output wire        rsp_valid,
  output wire [31:0] rsp_data,
  input  wire [1:0]  rx_word_valid,
  input  wire [31:0] rx1_word,
  input  wire [31:0] rx2_word,
  input  wire [1:0]  mailbox_capture_enable,
  input  wire [1:0]  label_filter_enable,
  input  wire [1:0]  sd_filter_enable,
  input  wire [1:0]  sd_match_bit_low,
  input  wire [1:0]  sd_match_bit_high,
  input  wire [7:0]  flag_irq_assign,
  input  wire        tx_auto_send,
  input  wire        tx_parity_enable,
  input  wire        tx_rate,
  output wire [1:0]  rx_fifo_empty,
  output wire [1:0]  rx_fifo_half,
  output wire [1:0]  rx_fifo_full,
  output wire [1:0]  mailbox1_available,
  output wire [1:0]  mailbox2_available,
  output wire [1:0]  mailbox3_available,
  output wire        rx1_mailbox1_ready_pin,
  output wire        rx1_mailbox2_ready_pin,
  output wire        rx1_mailbox3_ready_pin,
  output wire        rx2_mailbox1_ready_pin,
  output wire        rx2_mailbox2_ready_pin,
  output wire        rx2_mailbox3_ready_pin,
  output wire        rx1_irq_pin,
  output wire        rx2_irq_pin,
  output wire        rx1_flag_pin,
  output wire        rx2_flag_pin,
  output wire        tx_fifo_empty,
  output wire        tx_fifo_half,
  output wire        tx_fifo_full,
  output wire        line_out_pos,
  output wire        line_out_neg
);
  localparam [1:0] ST_IDLE = 2'd0;
  localparam [1:0] ST_DATA = 2'd1;
  localparam [1:0] ST_NULL = 2'd2;
  localparam [1:0] ST_GAP  = 2'd3;
  localparam integer TICK_LAST_I = `AWS_TICK_CYC - 1;
  localparam [7:0]   TICK_LAST   = TICK_LAST_I[7:0];

  wire        soft_rst = cmd_valid && (cmd_op == `AWS_OP_SOFT_RST);
  wire [5:0]  mb_avail;
  wire [1:0]  irq_w;
  wire [1:0]  flag_w;
  wire [31:0] rx_rsp [0:1];
  wire [1:0]  rx_hit;
  reg         rsp_valid_q;
  reg  [31:0] rsp_data_q;

  //////////////////////////////////////////////////////////////////////////////
  genvar r;
  genvar k;
  generate
    for (r = 0; r < 2; r = r + 1) begin : g_rx
      localparam [7:0] OP_LUT_WR   = r ? `AWS_OP_LUT_WR2   : `AWS_OP_LUT_WR1;
      localparam [7:0] OP_MATCH_WR = r ? `AWS_OP_MATCH_WR2 : `AWS_OP_MATCH_WR1;
      localparam [7:0] OP_LUT_RD   = r ? `AWS_OP_LUT_RD2   : `AWS_OP_LUT_RD1;
      localparam [7:0] OP_MATCH_RD = r ? `AWS_OP_MATCH_RD2 : `AWS_OP_MATCH_RD1;
      localparam [7:0] OP_FIFO_RD  = r ? `AWS_OP_FIFO_RD2  : `AWS_OP_FIFO_RD1;
      localparam [3:0] OP_MB_HI    = r ? `AWS_OP_MB_HI2    : `AWS_OP_MB_HI1;
      wire [31:0] w = r ? rx2_word : rx1_word;
      wire [7:0]  lab = w[7:0];
      reg  [255:0] lut_q;
      reg  [23:0]  match_q;
      reg  [71:0]  mbox_q;
      reg  [2:0]   avail_q;
      reg          irq_q;
      reg          flag_q;
      reg  [31:0]  rsp;
      reg          hit;
      wire [5:0]   cnt;
      wire [31:0]  fifo_out;
      // S/D gate applies first, to FIFO and mailboxes alike
      wire sd_ok = !sd_filter_enable[r] ||
                   (w[`AWS_SD_LO_POS] == sd_match_bit_low[r] &&
                    w[`AWS_SD_HI_POS] == sd_match_bit_high[r]);
      wire lab_ok = !label_filter_enable[r] || lut_q[lab];
      wire push = rx_word_valid[r] && sd_ok && lab_ok;
      wire rd_fifo = cmd_valid && (cmd_op == OP_FIFO_RD);
      wire mb_rd = cmd_valid && (cmd_op[7:4] == OP_MB_HI) &&
                   (cmd_op[1:0] == 2'b00) && (cmd_op[3:2] != 2'b00);
      wire [2:0] rd_oh = mb_rd ? (3'b001 << (cmd_op[3:2] - 2'd1)) : 3'b000;
      wire [2:0] cap;
      wire [1:0] fsel = r ? flag_irq_assign[5:4] : flag_irq_assign[1:0];
      wire [1:0] isel = r ? flag_irq_assign[7:6] : flag_irq_assign[3:2];

      aws_fifo #(
        .WIDTH (32),
        .DEPTH (`AWS_FIFO_DEPTH),
        .AW    (`AWS_FIFO_AW),
        .OVW   (1)
      ) u_rx_fifo (
        .clk       (clk),
        .rst       (rst),
        .flush     (soft_rst),
        .in_valid  (push),
        .in_data   (w),
        .in_ready  (),
        .out_valid (),
        .out_ready (rd_fifo),
        .out_data  (fifo_out),
        .count     (cnt)
      );

      assign rx_fifo_empty[r] = (cnt == 6'h00);
      assign rx_fifo_half[r]  = (cnt >= `AWS_FIFO_HALF);
      assign rx_fifo_full[r]  = (cnt == `AWS_FIFO_FULL);

      for (k = 0; k < 3; k = k + 1) begin : g_mb
        assign cap[k] = rx_word_valid[r] && mailbox_capture_enable[r] && sd_ok &&
                        (lab == match_q[8*k +: 8]);
        always @(posedge clk or posedge rst) begin
          if (rst) begin
            mbox_q[24*k +: 24] <= 24'h000000;
            avail_q[k]         <= 1'b0;
          end else if (soft_rst) begin
            mbox_q[24*k +: 24] <= 24'h000000;
            avail_q[k]         <= 1'b0;
          end else if (cap[k]) begin
            mbox_q[24*k +: 24] <= w[31:8];
            avail_q[k]         <= 1'b1;
          end else if (rd_oh[k]) begin
            avail_q[k] <= 1'b0;
          end
        end
      end
      assign mb_avail[3*r +: 3] = avail_q;

      // Table and match values survive soft reset
      always @(posedge clk or posedge rst) begin
        if (rst) begin
          lut_q   <= {256{1'b0}};
          match_q <= `AWS_MATCH_RST;
          irq_q   <= 1'b0;
          flag_q  <= 1'b0;
        end else begin
          if (cmd_valid && cmd_op == OP_LUT_WR)
            lut_q[{cmd_idx, 3'b000} +: 8] <= cmd_wdata[7:0];
          if (cmd_valid && cmd_op == OP_MATCH_WR)
            match_q <= cmd_wdata[23:0];
          case (isel)
            2'd1:    irq_q <= cap[0];
            2'd2:    irq_q <= cap[1];
            2'd3:    irq_q <= cap[2];
            default: irq_q <= 1'b0;
          endcase
          case (fsel)
            2'd0:    flag_q <= (cnt == 6'h00);
            2'd1:    flag_q <= (cnt >= `AWS_FIFO_HALF);
            2'd2:    flag_q <= (cnt == `AWS_FIFO_FULL);
            default: flag_q <= (cnt != 6'h00);
          endcase
        end
      end
      assign irq_w[r]  = irq_q;
      assign flag_w[r] = flag_q;

      always @* begin
        rsp = 32'h00000000;
        hit = cmd_valid;
        case (cmd_op)
          OP_LUT_RD:   rsp = {24'h000000, lut_q[{cmd_idx, 3'b000} +: 8]};
          OP_MATCH_RD: rsp = {8'h00, match_q};
          OP_FIFO_RD:  rsp = fifo_out;
          default: begin
            hit = mb_rd;
            case (cmd_op[3:2])
              2'd1:    rsp = {8'h00, mbox_q[23:0]};
              2'd2:    rsp = {8'h00, mbox_q[47:24]};
              default: rsp = {8'h00, mbox_q[71:48]};
            endcase
          end
        endcase
      end
      assign rx_rsp[r] = hit ? rsp : 32'h00000000;
      assign rx_hit[r] = hit;
    end
  endgenerate

  assign mailbox1_available     = {mb_avail[3], mb_avail[0]};
  assign mailbox2_available     = {mb_avail[4], mb_avail[1]};
  assign mailbox3_available     = {mb_avail[5], mb_avail[2]};
  assign rx1_mailbox1_ready_pin = mb_avail[0];
  assign rx1_mailbox2_ready_pin = mb_avail[1];
  assign rx1_mailbox3_ready_pin = mb_avail[2];
  assign rx2_mailbox1_ready_pin = mb_avail[3];
  assign rx2_mailbox2_ready_pin = mb_avail[4];
  assign rx2_mailbox3_ready_pin = mb_avail[5];
  assign rx1_irq_pin            = irq_w[0];
  assign rx2_irq_pin            = irq_w[1];
  assign rx1_flag_pin           = flag_w[0];
  assign rx2_flag_pin           = flag_w[1];

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rsp_valid_q <= 1'b0;
      rsp_data_q  <= 32'h00000000;
    end else begin
      rsp_valid_q <= |rx_hit;
      if (|rx_hit)
        rsp_data_q <= rx_rsp[0] | rx_rsp[1];
    end
  end
  assign rsp_valid = rsp_valid_q;
  assign rsp_data  = rsp_data_q;

  //////////////////////////////////////////////////////////////////////////////
  // Transmit path; ARINC clocks are 1 MHz ticks of the system clock
  reg  [7:0]  tick_cnt_q;
  reg         tick_q;
  reg  [1:0]  st_q;
  reg  [4:0]  bit_q;
  reg  [8:0]  ph_q;
  reg  [31:0] sh_q;
  reg         go_q;
  reg         ld_pend_q;
  reg         pos_q;
  reg         neg_q;
  wire [5:0]  tx_cnt;
  wire [31:0] tx_word;
  wire        tx_avail;
  wire        tx_ready;
  wire        ld = cmd_valid && (cmd_op == `AWS_OP_TX_LOAD);
  wire        pop_tx = (st_q == ST_IDLE) && go_q && tx_avail && tick_q;
  wire [8:0]  len_data = tx_rate ? `AWS_LS_DATA : `AWS_HS_DATA;
  wire [8:0]  len_null = tx_rate ? `AWS_LS_NULL : `AWS_HS_NULL;
  wire [8:0]  len_gap  = tx_rate ? `AWS_LS_GAP  : `AWS_HS_GAP;
  // Label goes out most significant bit first, the rest low to high
  wire [4:0]  idx = (bit_q[4:3] == 2'b00) ? {2'b00, ~bit_q[2:0]} : bit_q;
  wire        cur = sh_q[idx];

  aws_fifo #(
    .WIDTH (32),
    .DEPTH (`AWS_FIFO_DEPTH),
    .AW    (`AWS_FIFO_AW),
    .OVW   (0)
  ) u_tx_fifo (
    .clk       (clk),
    .rst       (rst),
    .flush     (soft_rst),
    .in_valid  (ld),
    .in_data   (cmd_wdata),
    .in_ready  (tx_ready),
    .out_valid (tx_avail),
    .out_ready (pop_tx),
    .out_data  (tx_word),
    .count     (tx_cnt)
  );

  assign tx_fifo_full  = (tx_cnt == `AWS_FIFO_FULL);
  assign tx_fifo_half  = (tx_cnt >= `AWS_FIFO_HALF);
  assign tx_fifo_empty = (tx_cnt == 6'h00) && (st_q == ST_IDLE);

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      tick_cnt_q <= 8'h00;
      tick_q     <= 1'b0;
    end else begin
      tick_q     <= (tick_cnt_q == TICK_LAST);
      tick_cnt_q <= (tick_cnt_q == TICK_LAST) ? 8'h00 : tick_cnt_q + 8'h01;
    end
  end

  // Sending stays enabled until the queue drains, so late loads still go
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      go_q      <= 1'b0;
      ld_pend_q <= 1'b0;
    end else if (soft_rst) begin
      go_q      <= 1'b0;
      ld_pend_q <= 1'b0;
    end else begin
      if (tx_auto_send && cmd_end && (ld_pend_q || (ld && tx_ready)))
        go_q <= 1'b1;
      else if (!tx_auto_send && cmd_valid && cmd_op == `AWS_OP_TX_SEND)
        go_q <= 1'b1;
      else if (st_q == ST_IDLE && !tx_avail)
        go_q <= 1'b0;
      // A load ending with the same strobe is consumed above, not kept
      if (cmd_end)
        ld_pend_q <= 1'b0;
      else if (ld && tx_ready)
        ld_pend_q <= 1'b1;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q  <= ST_IDLE;
      bit_q <= 5'd0;
      ph_q  <= 9'd0;
      sh_q  <= 32'h00000000;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (pop_tx) begin
            sh_q  <= tx_parity_enable ?
                     {~^tx_word[30:0], tx_word[30:0]} : tx_word;
            bit_q <= 5'd0;
            ph_q  <= len_data - 9'd1;
            st_q  <= ST_DATA;
          end
        end
        ST_DATA: begin
          if (tick_q) begin
            if (ph_q == 9'd0) begin
              ph_q <= len_null - 9'd1;
              st_q <= ST_NULL;
            end else begin
              ph_q <= ph_q - 9'd1;
            end
          end
        end
        ST_NULL: begin
          if (tick_q) begin
            if (ph_q != 9'd0) begin
              ph_q <= ph_q - 9'd1;
            end else if (bit_q == 5'd31) begin
              ph_q <= len_gap - 9'd1;
              st_q <= ST_GAP;
            end else begin
              bit_q <= bit_q + 5'd1;
              ph_q  <= len_data - 9'd1;
              st_q  <= ST_DATA;
            end
          end
        end
        ST_GAP: begin
          if (tick_q) begin
            if (ph_q == 9'd0)
              st_q <= ST_IDLE;
            else
              ph_q <= ph_q - 9'd1;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pos_q <= 1'b0;
      neg_q <= 1'b0;
    end else begin
      pos_q <= (st_q == ST_DATA) && cur;
      neg_q <= (st_q == ST_DATA) && !cur;
    end
  end
  assign line_out_pos = pos_q;
  assign line_out_neg = neg_q;
endmodule

`default_nettype wire

// *** testbench/aws_top_assertions.sv ***
// Concurrent checks on the ports of the store-and-send top.
// Assumes start latency is only timed for high-speed auto sends.
`default_nettype none
module aws_top_chk (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        cmd_valid,
  input wire logic [7:0]  cmd_op,
  input wire logic        cmd_end,
  input wire logic        rsp_valid,
  input wire logic [1:0]  rx_word_valid,
  input wire logic [31:0] rx1_word,
  input wire logic [1:0]  mailbox_capture_enable,
  input wire logic [1:0]  sd_filter_enable,
  input wire logic [1:0]  sd_match_bit_low,
  input wire logic [1:0]  sd_match_bit_high,
  input wire logic [7:0]  flag_irq_assign,
  input wire logic        tx_auto_send,
  input wire logic        tx_rate,
  input wire logic [1:0]  rx_fifo_empty,
  input wire logic [1:0]  rx_fifo_half,
  input wire logic [1:0]  rx_fifo_full,
  input wire logic [1:0]  mailbox1_available,
  input wire logic        rx1_mailbox1_ready_pin,
  input wire logic        rx1_irq_pin,
  input wire logic        rx1_flag_pin,
  input wire logic        tx_fifo_empty,
  input wire logic        tx_fifo_half,
  input wire logic        tx_fifo_full,
  input wire logic        line_out_pos,
  input wire logic        line_out_neg
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // Quiet time longer than a word gap means the serializer is truly idle
  logic [13:0] idle_q;
  always @(posedge clk or posedge rst) begin
    if (rst) idle_q <= 14'h3FFF;
    else if (line_out_pos || line_out_neg) idle_q <= 14'h0000;
    else if (idle_q != 14'h3FFF) idle_q <= idle_q + 14'h0001;
  end

  sequence s_send_start;
    cmd_valid && cmd_op == 8'h0C && cmd_end && tx_auto_send && !tx_rate && tx_fifo_empty
      && idle_q > 14'h2328;
  endsequence
  sequence s_line_active;
    line_out_pos || line_out_neg;
  endsequence

  a_empty_no_half: assert property (rx_fifo_empty[0] |-> !rx_fifo_half[0] && !rx_fifo_full[0])
    else $error("receive empty with half or full set");
  a_full_has_half: assert property (rx_fifo_full[0] |-> rx_fifo_half[0])
    else $error("receive full without half");
  a_read_answer_next: assert property (cmd_valid && cmd_op == 8'hA0 |=> rsp_valid)
    else $error("fifo read gave no answer");
  a_capture_needs_enable: assert property ($rose(mailbox1_available[0]) |->
    $past(mailbox_capture_enable[0] && rx_word_valid[0])) else $error("capture while disabled");
  a_ready_pin_follows: assert property (rx1_mailbox1_ready_pin == mailbox1_available[0])
    else $error("ready pin differs from status");
  a_line_never_both: assert property (!(line_out_pos && line_out_neg))
    else $error("both line outputs high");
  a_tx_empty_flags: assert property (tx_fifo_empty |-> !tx_fifo_half && !tx_fifo_full)
    else $error("transmit empty with half or full");
  a_sd_mismatch_drop: assert property (rx_word_valid[0] && sd_filter_enable[0] && rx_fifo_empty[0]
    && rx1_word[9:8] != {sd_match_bit_high[0], sd_match_bit_low[0]} |=> rx_fifo_empty[0])
    else $error("mismatching word stored");
  a_flag_not_empty: assert property (flag_irq_assign[1:0] == 2'b11 |=>
    rx1_flag_pin == !$past(rx_fifo_empty[0])) else $error("flag pin not tracking");
  a_irq_from_word: assert property (rx1_irq_pin |->
    $past(rx_word_valid[0]) || $past(rx_word_valid[0], 2)) else $error("interrupt without word");
  a_tx_start_bound: assert property (s_send_start |-> ##[1:500] s_line_active)
    else $error("first bit late");
endmodule

bind aws_top aws_top_chk chk_u (.clk, .rst, .cmd_valid, .cmd_op, .cmd_end, .rsp_valid,
  .rx_word_valid, .rx1_word, .mailbox_capture_enable, .sd_filter_enable, .sd_match_bit_low,
  .sd_match_bit_high, .flag_irq_assign, .tx_auto_send, .tx_rate, .rx_fifo_empty, .rx_fifo_half,
  .rx_fifo_full, .mailbox1_available, .rx1_mailbox1_ready_pin, .rx1_irq_pin, .rx1_flag_pin,
  .tx_fifo_empty, .tx_fifo_half, .tx_fifo_full, .line_out_pos, .line_out_neg);
`default_nettype wire

// *** testbench/aws_line_mon.sv ***
// Bus-side receiver model: rebuilds each word sent on the line pair.
// Assumes one return-to-null pulse per bit, label byte first.
`default_nettype none
module aws_line_mon (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        line_pos,
  input  wire logic        line_neg,
  output var  logic [31:0] word,
  output var  logic        done,
  output var  logic [15:0] width
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [5:0]  cnt_q;
  logic        prev_q;
  logic [15:0] run_q;
  wire logic   act = line_pos | line_neg;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 6'h00;
      prev_q <= 1'b0;
      run_q <= 16'h0000;
      word <= 32'h00000000;
      done <= 1'b0;
      width <= 16'h0000;
    end else begin
      prev_q <= act;
      done <= 1'b0;
      run_q <= act ? run_q + 16'h0001 : 16'h0000;
      if (!act && prev_q) width <= run_q;
      if (act && !prev_q) begin
        // Label goes out most significant bit first
        if (cnt_q < 6'h08) word[3'h7 - cnt_q[2:0]] <= line_pos;
        else word[cnt_q[4:0]] <= line_pos;
        cnt_q <= (cnt_q == 6'h1F) ? 6'h00 : cnt_q + 6'h01;
        done <= (cnt_q == 6'h1F);
      end
    end
  end
endmodule
`default_nettype wire

// *** testbench/aws_top_tb.sv ***
// Self-checking bench for the store-and-send top and a line receiver model.
// Assumes the 1 MHz tick is derived inside from the 200 MHz clock.
`default_nettype none
module aws_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk, rst, cmd_valid, cmd_end, rsp_valid, tx_auto_send, tx_parity_enable, tx_rate;
  logic [7:0]  cmd_op, flag_irq_assign;
  logic [4:0]  cmd_idx;
  logic [31:0] cmd_wdata, rsp_data, rx1_word, rx2_word, mon_word;
  logic [1:0]  rx_word_valid, mailbox_capture_enable, label_filter_enable, sd_filter_enable;
  logic [1:0]  sd_match_bit_low, sd_match_bit_high, rx_fifo_empty, rx_fifo_half, rx_fifo_full;
  logic [1:0]  mailbox1_available, mailbox2_available, mailbox3_available;
  logic        rx1_mailbox1_ready_pin, rx1_mailbox2_ready_pin, rx1_mailbox3_ready_pin;
  logic        rx2_mailbox1_ready_pin, rx2_mailbox2_ready_pin, rx2_mailbox3_ready_pin;
  logic        rx1_irq_pin, rx2_irq_pin, rx1_flag_pin, rx2_flag_pin, mon_done;
  logic        tx_fifo_empty, tx_fifo_half, tx_fifo_full, line_out_pos, line_out_neg;
  logic [15:0] mon_width;
  int          fail_count = 0;
  int          tests_run = 0;

  aws_top dut_u (.*);
  aws_line_mon mon_u (.clk(clk), .rst(rst), .line_pos(line_out_pos), .line_neg(line_out_neg),
    .word(mon_word), .done(mon_done), .width(mon_width));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Returns one falling edge after the taking edge, where answers are settled
  task automatic cmd(input logic [7:0] op, input logic [4:0] idx, input logic [31:0] wd,
                     input logic e);
    @(negedge clk);
    {cmd_valid, cmd_op, cmd_idx, cmd_wdata, cmd_end} = {1'b1, op, idx, wd, e};
    @(negedge clk);
    {cmd_valid, cmd_end} = 2'h0;
  endtask

  task automatic rxw(input logic [31:0] w);
    @(negedge clk);
    {rx_word_valid, rx1_word} = {2'h1, w};
    @(negedge clk);
    rx_word_valid = 2'h0;
  endtask

  task automatic t_tx_send();
    int n;
    logic [31:0] w;
    w = 32'h800000F1;
    {tx_auto_send, tx_parity_enable} = 2'h3;
    cmd(8'h0C, 5'h00, w, 1'b1);
    for (n = 0; n < 600 && !(line_out_pos | line_out_neg); n++) @(negedge clk);
    chk(n <= 500, 1);
    for (n = 0; n < 80000 && !mon_done; n++) @(negedge clk);
    chk(mon_word, 32'h000000F1);
    chk(mon_width, 16'h03E8);
    // Empty only once the last bit and the word gap are over
    for (n = 0; n < 12000 && !tx_fifo_empty; n++) @(negedge clk);
    chk(tx_fifo_empty, 1);
  endtask

  task automatic t_tx_manual();
    int n;
    {tx_auto_send, tx_parity_enable, tx_rate} = 3'h1;
    cmd(8'h0C, 5'h00, 32'h00000080, 1'b1);
    repeat (400) @(negedge clk);
    chk(line_out_pos | line_out_neg, 0);
    cmd(8'h40, 5'h00, 32'h0, 1'b0);
    for (n = 0; n < 600 && !(line_out_pos | line_out_neg); n++) @(negedge clk);
    chk({n <= 500, line_out_pos}, 2'h3);
    for (n = 0; n < 9000 && (line_out_pos | line_out_neg); n++) @(negedge clk);
    @(negedge clk);
    chk(mon_width, 16'h1F40);
  endtask

  task automatic t_tx_fill();
    tx_auto_send = 1'b0;
    for (int i = 0; i < 33; i++) begin
      cmd(8'h0C, 5'h00, i, 1'b0);
      if (i == 14) chk(tx_fifo_half, 0);
      if (i == 31) chk(tx_fifo_full, 1);
    end
    chk(line_out_pos | line_out_neg, 0);
    cmd(8'h44, 5'h00, 32'h0, 1'b0);
    chk({tx_fifo_empty, tx_fifo_full}, 2'h2);
  endtask

  task automatic t_rx_filter();
    cmd(8'h14, 5'h04, 32'h02, 1'b0);
    cmd(8'h98, 5'h04, 32'h0, 1'b0);
    chk(rsp_data[7:0], 8'h02);
    {label_filter_enable, sd_filter_enable, sd_match_bit_high} = 6'h15;
    rxw(32'hABCDE121);
    rxw(32'hABCDE222);
    chk(rx_fifo_empty[0], 1);
    rxw(32'hABCDE221);
    chk(rx_fifo_empty[0], 0);
    cmd(8'hA0, 5'h00, 32'h0, 1'b0);
    chk({rsp_valid, rsp_data}, {1'b1, 32'hABCDE221});
    chk(rx_fifo_empty[0], 1);
    {label_filter_enable, sd_filter_enable, sd_match_bit_high} = 6'h00;
  endtask

  task automatic t_mailbox();
    logic seen;
    cmd(8'h18, 5'h00, 32'h00332211, 1'b0);
    cmd(8'h9C, 5'h00, 32'h0, 1'b0);
    chk(rsp_data[23:0], 24'h332211);
    rxw(32'h12345611);
    chk(mailbox1_available[0], 0);
    {mailbox_capture_enable, flag_irq_assign} = {2'h1, 8'h04};
    rxw(32'h12345611);
    seen = rx1_irq_pin;
    @(negedge clk);
    chk(seen | rx1_irq_pin, 1);
    chk({mailbox1_available[0], rx1_mailbox1_ready_pin}, 2'h3);
    cmd(8'hA4, 5'h00, 32'h0, 1'b0);
    chk(rsp_data[23:0], 24'h123456);
    chk(mailbox1_available[0], 0);
  endtask

  task automatic t_fill();
    flag_irq_assign = 8'h03;
    cmd(8'h44, 5'h00, 32'h0, 1'b0);
    chk(rx_fifo_empty[0], 1);
    for (int i = 0; i < 33; i++) begin
      rxw(i);
      if (i == 14) chk(rx_fifo_half[0], 0);
      if (i == 15) chk(rx_fifo_half[0], 1);
      if (i == 31) chk(rx_fifo_full[0], 1);
    end
    chk(rx1_flag_pin, 1);
    for (int i = 0; i < 32; i++) begin
      cmd(8'hA0, 5'h00, 32'h0, 1'b0);
      chk(rsp_data, (i == 31) ? 32'h20 : i);
    end
    cmd(8'hA0, 5'h00, 32'h0, 1'b0);
    chk({rx_fifo_empty[0], rx_fifo_full[0], rx1_flag_pin}, 3'h4);
  endtask

  task automatic results();
    $display("Checks run %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    #450000;
    fail_count++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    results();
  end

  initial begin
    {cmd_valid, cmd_end, tx_auto_send, tx_parity_enable, tx_rate} = 5'h00;
    {cmd_op, flag_irq_assign, cmd_idx, cmd_wdata, rx1_word, rx2_word} = 117'h0;
    {rx_word_valid, mailbox_capture_enable, label_filter_enable} = 6'h00;
    {sd_filter_enable, sd_match_bit_low, sd_match_bit_high} = 6'h00;
    rst = 1'b1;
    repeat (12) @(posedge clk);
    @(negedge clk) rst = 1'b0;
    chk({rx_fifo_empty[0], rx_fifo_half[0], rx_fifo_full[0], tx_fifo_empty}, 4'h9);
    t_tx_send();
    t_tx_fill();
    t_rx_filter();
    t_mailbox();
    t_fill();
    t_tx_manual();
    results();
  end
endmodule
`default_nettype wire
